// ### hw/epv_pkg.sv
package epv_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int WORD_W = 12;
  localparam int LOW_W = 4;
  localparam int HIGH_W = 8;
  localparam int TMR_W = 14;

  localparam logic [11:0] CONFIG_ADDR = 12'hFFF;
  localparam logic [11:0] FIRST_USER_ADDR = 12'h000;
  localparam logic [11:0] LAST_PC_ADDR = 12'hFFE;
  localparam logic [11:0] BLANK_WORD = 12'hFFF;
  localparam logic [1:0] OSC_KEEP_BITS = 2'h3;

  localparam logic [3:0] MAX_PULSES = 4'h8;
  localparam logic [3:0] OVER_MULT_RESET = 4'hB;

  localparam logic [1:0] SUPPLY_NOMINAL = 2'h0;
  localparam logic [1:0] SUPPLY_MIN = 2'h1;
  localparam logic [1:0] SUPPLY_MAX = 2'h2;

  localparam int PROG_PULSE_NS = 100000;
  localparam int VERIFY_PULSE_NS = 1000;
  localparam int SETUP_NS = 1000;
  localparam int RESET_LOW_NS = 10000;
  localparam int STEP_HALF_NS = 1000;

  localparam int PROG_PULSE_CYC = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VERIFY_PULSE_CYC = (VERIFY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_HALF_CYC = (STEP_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_ENTER,
    OP_EXIT,
    OP_PROGRAM,
    OP_STEP_READ
  } epv_op_type;

  typedef enum {
    ST_IDLE,
    ST_RST_LOW,
    ST_ENTRY_WAIT,
    ST_PRG_SETUP,
    ST_PRG_PULSE,
    ST_VER_GAP,
    ST_VER_PULSE,
    ST_STEP_HI,
    ST_STEP_LO,
    ST_TAIL
  } epv_state_type;

endpackage

// ### hw/epv_timer.sv
`timescale 1ns/1ns
module epv_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [epv_pkg::TMR_W-1:0] cycles,
  output logic done_ff
);

  logic [epv_pkg::TMR_W-1:0] count_ff;
  logic busy_ff;

  // A zero length is treated as one cycle so a wait can never hang.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (start) begin
      count_ff <= cycles;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff && count_ff <= 14'h0001) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b1;
    end else begin
      count_ff <= busy_ff ? count_ff - 14'h0001 : count_ff;
      done_ff <= 1'b0;
    end
  end

endmodule // epv_timer

// ### hw/epv_programmer.sv
`timescale 1ns/1ns
// Functional notes
// - Enter by raising clear, strobe high, step low.
// - Word low nibble on low port, rest high.
// - Repeat program and verify pairs until pass.
// - Location N after N+1 steps, held while high.
// - Blank check at minimum supply first; no blank check is run, supply_sel_ff only follows cmd_supply.
// - Verify each pulse, fail after eight.
// - Overprogram adjustable multiple of pulses used.
// - Final fast verify at minimum then maximum supply.
// - Keep two lowest bits one for configuration.
module epv_programmer #(
  parameter int PROG_CYC = epv_pkg::PROG_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [11:0] cmd_data,
  input wire logic cmd_config,
  input wire logic cmd_cmp_en,
  input wire logic [1:0] cmd_supply,
  input wire logic [3:0] over_mult,
  input wire logic [3:0] low_data_port_i,
  input wire logic [7:0] high_data_port_i,
  output logic cmd_ready_ff,
  output logic done_ff,
  output logic fail_ff,
  output logic [11:0] rd_data_ff,
  output logic [3:0] pulse_used_ff,
  output logic [11:0] addr_ff,
  output logic in_mode_ff,
  output logic master_clear_hv_ff,
  output logic prog_verify_strobe_ff,
  output logic address_step_input_ff,
  output logic [3:0] low_data_port_o_ff,
  output logic [7:0] high_data_port_o_ff,
  output logic data_oe_ff,
  output logic [1:0] supply_sel_ff
);

  epv_pkg::epv_state_type state_ff;
  logic tmr_start_ff;
  logic [epv_pkg::TMR_W-1:0] tmr_len_ff;
  logic tmr_done;
  logic [11:0] word_ff;
  logic cfg_ff;
  logic cmp_en_ff;
  logic over_ff;
  logic [7:0] over_left_ff;
  logic [11:0] pin_word;

  localparam logic [13:0] PROG_LEN = PROG_CYC[13:0];
  localparam logic [13:0] VER_LEN = epv_pkg::VERIFY_PULSE_CYC[13:0];
  localparam logic [13:0] SETUP_LEN = epv_pkg::SETUP_CYC[13:0];
  localparam logic [13:0] RST_LEN = epv_pkg::RESET_LOW_CYC[13:0];
  localparam logic [13:0] STEP_LEN = epv_pkg::STEP_HALF_CYC[13:0];

  // The device counter wraps from the last address to zero and never lands on
  // the configuration word again, so the mirror copies that.
  function automatic logic [11:0] next_addr(input logic [11:0] a);
    if (a == epv_pkg::CONFIG_ADDR || a == epv_pkg::LAST_PC_ADDR) begin
      return epv_pkg::FIRST_USER_ADDR;
    end
    return a + 12'h001;
  endfunction

  function automatic logic [7:0] over_count(input logic [3:0] m, input logic [3:0] n);
    // Widened first so the product of two nibbles never loses its top bits.
    return {4'h0, m} * {4'h0, n};
  endfunction

  assign pin_word = {high_data_port_i, low_data_port_i};

  epv_timer u_timer (
    .clk(clk),
    .rst(rst),
    .start(tmr_start_ff),
    .cycles(tmr_len_ff),
    .done_ff(tmr_done)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= epv_pkg::ST_IDLE;
      cmd_ready_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      rd_data_ff <= 12'h000;
      pulse_used_ff <= 4'h0;
      addr_ff <= epv_pkg::CONFIG_ADDR;
      in_mode_ff <= 1'b0;
      master_clear_hv_ff <= 1'b0;
      prog_verify_strobe_ff <= 1'b1;
      address_step_input_ff <= 1'b0;
      data_oe_ff <= 1'b0;
      low_data_port_o_ff <= 4'h0;
      high_data_port_o_ff <= 8'h00;
      supply_sel_ff <= epv_pkg::SUPPLY_NOMINAL;
      tmr_start_ff <= 1'b0;
      tmr_len_ff <= 14'h0001;
      word_ff <= 12'h000;
      cfg_ff <= 1'b0;
      cmp_en_ff <= 1'b0;
      over_ff <= 1'b0;
      over_left_ff <= 8'h00;
    end else begin
      tmr_start_ff <= 1'b0;
      done_ff <= 1'b0;
      unique case (state_ff)
        epv_pkg::ST_IDLE: begin
          cmd_ready_ff <= 1'b1;
          if (cmd_valid && cmd_ready_ff) begin
            cmd_ready_ff <= 1'b0;
            fail_ff <= 1'b0;
            supply_sel_ff <= cmd_supply;
            cfg_ff <= cmd_config;
            cmp_en_ff <= cmd_cmp_en;
            word_ff <= cmd_config ? {cmd_data[11:2], epv_pkg::OSC_KEEP_BITS} : cmd_data;
            if (cmd_op == 3'(epv_pkg::OP_ENTER)) begin
              master_clear_hv_ff <= 1'b0;
              prog_verify_strobe_ff <= 1'b1;
              address_step_input_ff <= 1'b0;
              data_oe_ff <= 1'b0;
              in_mode_ff <= 1'b0;
              tmr_len_ff <= RST_LEN;
              tmr_start_ff <= 1'b1;
              state_ff <= epv_pkg::ST_RST_LOW;
            end else if (cmd_op == 3'(epv_pkg::OP_EXIT)) begin
              master_clear_hv_ff <= 1'b0;
              in_mode_ff <= 1'b0;
              data_oe_ff <= 1'b0;
              done_ff <= 1'b1;
            end else if (!in_mode_ff) begin
              // Access outside the mode is refused rather than driven blind.
              fail_ff <= 1'b1;
              done_ff <= 1'b1;
            end else if (cmd_op == 3'(epv_pkg::OP_PROGRAM)) begin
              low_data_port_o_ff <= cmd_config ? {cmd_data[3:2], epv_pkg::OSC_KEEP_BITS}
                                                : cmd_data[3:0];
              high_data_port_o_ff <= cmd_data[11:4];
              data_oe_ff <= 1'b1;
              pulse_used_ff <= 4'h0;
              over_ff <= 1'b0;
              tmr_len_ff <= SETUP_LEN;
              tmr_start_ff <= 1'b1;
              state_ff <= epv_pkg::ST_PRG_SETUP;
            end else if (cmd_op == 3'(epv_pkg::OP_STEP_READ)) begin
              address_step_input_ff <= 1'b1;
              tmr_len_ff <= STEP_LEN;
              tmr_start_ff <= 1'b1;
              state_ff <= epv_pkg::ST_STEP_HI;
            end else begin
              fail_ff <= 1'b1;
              done_ff <= 1'b1;
            end
          end
        end
        epv_pkg::ST_RST_LOW: begin
          if (tmr_done) begin
            master_clear_hv_ff <= 1'b1;
            addr_ff <= epv_pkg::CONFIG_ADDR;
            in_mode_ff <= 1'b1;
            tmr_len_ff <= SETUP_LEN;
            tmr_start_ff <= 1'b1;
            state_ff <= epv_pkg::ST_ENTRY_WAIT;
          end
        end
        epv_pkg::ST_ENTRY_WAIT: begin
          if (tmr_done) begin
            done_ff <= 1'b1;
            state_ff <= epv_pkg::ST_IDLE;
          end
        end
        epv_pkg::ST_PRG_SETUP: begin
          if (tmr_done) begin
            prog_verify_strobe_ff <= 1'b0;
            if (!over_ff) begin
              pulse_used_ff <= pulse_used_ff + 4'h1;
            end
            tmr_len_ff <= PROG_LEN;
            tmr_start_ff <= 1'b1;
            state_ff <= epv_pkg::ST_PRG_PULSE;
          end
        end
        epv_pkg::ST_PRG_PULSE: begin
          if (tmr_done) begin
            prog_verify_strobe_ff <= 1'b1;
            data_oe_ff <= 1'b0;
            tmr_len_ff <= SETUP_LEN;
            tmr_start_ff <= 1'b1;
            state_ff <= epv_pkg::ST_VER_GAP;
          end
        end
        epv_pkg::ST_VER_GAP: begin
          if (tmr_done) begin
            prog_verify_strobe_ff <= 1'b0;
            tmr_len_ff <= VER_LEN;
            tmr_start_ff <= 1'b1;
            state_ff <= epv_pkg::ST_VER_PULSE;
          end
        end
        epv_pkg::ST_VER_PULSE: begin
          if (tmr_done) begin
            rd_data_ff <= pin_word;
            prog_verify_strobe_ff <= 1'b1;
            tmr_len_ff <= SETUP_LEN;
            tmr_start_ff <= 1'b1;
            // Overprogram pairs still verify so strobe parity stays aligned.
            if (over_ff) begin
              if (over_left_ff <= 8'h01) begin
                state_ff <= epv_pkg::ST_TAIL;
              end else begin
                over_left_ff <= over_left_ff - 8'h01;
                data_oe_ff <= 1'b1;
                state_ff <= epv_pkg::ST_PRG_SETUP;
              end
            end else if (pin_word == word_ff) begin
              over_ff <= 1'b1;
              over_left_ff <= over_count(over_mult, pulse_used_ff);
              if (over_count(over_mult, pulse_used_ff) == 8'h00) begin
                state_ff <= epv_pkg::ST_TAIL;
              end else begin
                data_oe_ff <= 1'b1;
                state_ff <= epv_pkg::ST_PRG_SETUP;
              end
            end else if (pulse_used_ff >= epv_pkg::MAX_PULSES) begin
              fail_ff <= 1'b1;
              state_ff <= epv_pkg::ST_TAIL;
            end else begin
              data_oe_ff <= 1'b1;
              state_ff <= epv_pkg::ST_PRG_SETUP;
            end
          end
        end
        epv_pkg::ST_STEP_HI: begin
          if (tmr_done) begin
            rd_data_ff <= pin_word;
            if (cmp_en_ff && pin_word != word_ff) begin
              fail_ff <= 1'b1;
            end
            address_step_input_ff <= 1'b0;
            addr_ff <= next_addr(addr_ff);
            tmr_len_ff <= STEP_LEN;
            tmr_start_ff <= 1'b1;
            state_ff <= epv_pkg::ST_STEP_LO;
          end
        end
        epv_pkg::ST_STEP_LO, epv_pkg::ST_TAIL: begin
          if (tmr_done) begin
            done_ff <= 1'b1;
            state_ff <= epv_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  property p_entry_levels;
    @(posedge clk) disable iff (rst)
    $rose(master_clear_hv_ff) |-> prog_verify_strobe_ff && !address_step_input_ff;
  endproperty
  a_entry_levels: assert property (p_entry_levels) else $error("bad entry levels");

  property p_release_verify;
    @(posedge clk) disable iff (rst)
    (!prog_verify_strobe_ff && state_ff != epv_pkg::ST_PRG_PULSE) |-> !data_oe_ff;
  endproperty
  a_release_verify: assert property (p_release_verify) else $error("data driven in verify");

  property p_step_strobe;
    @(posedge clk) disable iff (rst)
    address_step_input_ff |-> prog_verify_strobe_ff && in_mode_ff;
  endproperty
  a_step_strobe: assert property (p_step_strobe) else $error("step with strobe low");

  property p_pulse_max;
    @(posedge clk) disable iff (rst)
    pulse_used_ff <= epv_pkg::MAX_PULSES;
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("too many pulses");

  property p_config_bits;
    @(posedge clk) disable iff (rst)
    (cfg_ff && data_oe_ff) |-> low_data_port_o_ff[1:0] == epv_pkg::OSC_KEEP_BITS;
  endproperty
  a_config_bits: assert property (p_config_bits) else $error("osc bits not held");

  property p_data_map;
    @(posedge clk) disable iff (rst)
    data_oe_ff |-> {high_data_port_o_ff, low_data_port_o_ff} == word_ff;
  endproperty
  a_data_map: assert property (p_data_map) else $error("data lanes wrong");

  property p_pair_after_prog;
    @(posedge clk) disable iff (rst)
    (state_ff == epv_pkg::ST_PRG_PULSE && tmr_done) |=> state_ff == epv_pkg::ST_VER_GAP
      ##[1:1000] state_ff == epv_pkg::ST_VER_PULSE;
  endproperty
  a_pair_after_prog: assert property (p_pair_after_prog) else $error("no verify after pulse");

  property p_over_count_frozen;
    @(posedge clk) disable iff (rst)
    (over_ff && state_ff == epv_pkg::ST_PRG_PULSE) |-> $stable(pulse_used_ff);
  endproperty
  a_over_count_frozen: assert property (p_over_count_frozen) else $error("over pulse counted");

endmodule // epv_programmer

// ### bench/epv_device_model.sv
`timescale 1ns/1ns
module epv_device_model (
  input wire logic master_clear_hv,
  input wire logic prog_verify_strobe,
  input wire logic address_step_input,
  input wire logic [11:0] data_in,
  input wire logic [3:0] need_pulses,
  output logic [11:0] data_out,
  output logic data_oe
);
  logic [11:0] mem [4096];
  logic [11:0] pc;
  logic in_mode;
  logic verify_next;
  logic [7:0] pulses;
  initial begin
    foreach (mem[i]) mem[i] = 12'hFFF;
    pc = 12'hFFF;
    in_mode = 1'b0;
    verify_next = 1'b0;
    pulses = 8'h00;
  end
  always @(posedge master_clear_hv) begin
    if (prog_verify_strobe === 1'b1 && address_step_input === 1'b0) begin
      in_mode = 1'b1;
      pc = 12'hFFF;
      verify_next = 1'b0;
      pulses = 8'h00;
    end
  end
  always @(negedge master_clear_hv) in_mode = 1'b0;
  // The counter skips the configuration word, so it is reached only by re-entry.
  always @(negedge address_step_input) begin
    if (in_mode) begin
      pc = (pc >= 12'hFFE) ? 12'h000 : pc + 12'h001;
      pulses = 8'h00;
    end
  end
  // A slow cell only takes the word after need_pulses program pulses.
  always @(negedge prog_verify_strobe) begin
    if (in_mode && !verify_next) begin
      pulses = pulses + 8'h01;
      if (pulses >= {4'h0, need_pulses}) mem[pc] = mem[pc] & data_in;
    end
  end
  always @(posedge prog_verify_strobe) if (in_mode) verify_next = !verify_next;
  assign data_oe = in_mode && ((!prog_verify_strobe && verify_next) ||
                   (prog_verify_strobe && address_step_input));
  assign data_out = mem[pc];
endmodule  // epv_device_model

// ### bench/eprom_program_verify_port_tb_top.sv
`timescale 1ns/1ns
module eprom_program_verify_port_tb_top;
  logic clk, rst, cmd_valid, cmd_config, cmd_cmp_en, dev_oe;
  logic [2:0] cmd_op;
  logic [1:0] cmd_supply;
  logic [3:0] over_mult, need_pulses;
  logic [11:0] cmd_data, wire_val, last_wire, dev_data;
  logic cmd_ready_ff, done_ff, fail_ff, in_mode_ff, master_clear_hv_ff;
  logic prog_verify_strobe_ff, address_step_input_ff, data_oe_ff;
  logic [11:0] rd_data_ff, addr_ff;
  logic [3:0] pulse_used_ff, low_data_port_o_ff;
  logic [7:0] high_data_port_o_ff;
  logic [1:0] supply_sel_ff;
  int mismatches = 0;
  int n_tests = 0;
  // A released wire shows a value that flips each cycle, never a stale word.
  assign wire_val = dev_oe ? dev_data :
                    (data_oe_ff ? {high_data_port_o_ff, low_data_port_o_ff} : ~last_wire);
  always @(posedge clk) last_wire <= wire_val;
  always #(epv_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  epv_programmer #(.PROG_CYC(20)) dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_config(cmd_config), .cmd_cmp_en(cmd_cmp_en),
    .cmd_supply(cmd_supply), .over_mult(over_mult), .low_data_port_i(wire_val[3:0]),
    .high_data_port_i(wire_val[11:4]), .cmd_ready_ff(cmd_ready_ff), .done_ff(done_ff),
    .fail_ff(fail_ff), .rd_data_ff(rd_data_ff), .pulse_used_ff(pulse_used_ff),
    .addr_ff(addr_ff), .in_mode_ff(in_mode_ff), .master_clear_hv_ff(master_clear_hv_ff),
    .prog_verify_strobe_ff(prog_verify_strobe_ff),
    .address_step_input_ff(address_step_input_ff), .low_data_port_o_ff(low_data_port_o_ff),
    .high_data_port_o_ff(high_data_port_o_ff), .data_oe_ff(data_oe_ff),
    .supply_sel_ff(supply_sel_ff));
  epv_device_model model (.master_clear_hv(master_clear_hv_ff),
    .prog_verify_strobe(prog_verify_strobe_ff), .address_step_input(address_step_input_ff),
    .data_in(wire_val), .need_pulses(need_pulses), .data_out(dev_data), .data_oe(dev_oe));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Looked at on the falling edge so both drivers have settled after the clock.
  always @(negedge clk) if (dev_oe === 1'b1) chk({11'h0, data_oe_ff}, 12'h000);
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_cmd(input logic [2:0] op, input logic [11:0] d, input logic cfg,
                        input logic cmp, input logic [1:0] sup);
    int n;
    n = 0;
    cmd_op = op;
    cmd_data = d;
    cmd_config = cfg;
    cmd_cmp_en = cmp;
    cmd_supply = sup;
    cmd_valid = 1'b1;
    while (cmd_ready_ff !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1 cmd_valid = 1'b0;
    while (done_ff !== 1'b1 && n < 30000) begin
      @(posedge clk) #1 n++;
    end
    if (n >= 30000) mismatches++;
  endtask
  task automatic t_enter(input logic [1:0] sup);
    do_cmd(3'h0, 12'h000, 1'b0, 1'b0, sup);
    chk({11'h0, in_mode_ff}, 12'h001);
    chk({11'h0, model.in_mode}, 12'h001);
    chk(addr_ff, 12'hFFF);
    chk(model.pc, 12'hFFF);
    chk({10'h0, supply_sel_ff}, {10'h0, sup});
  endtask
  task automatic t_program(input logic [11:0] d, input logic cfg, input logic [3:0] need,
                           input logic [3:0] mult, input logic [11:0] word,
                           input logic [3:0] used, input logic fl, input logic [7:0] pulses);
    need_pulses = need;
    over_mult = mult;
    do_cmd(3'h2, d, cfg, 1'b0, epv_pkg::SUPPLY_NOMINAL);
    chk({11'h0, fail_ff}, {11'h0, fl});
    chk({8'h0, pulse_used_ff}, {8'h0, used});
    chk({4'h0, model.pulses}, {4'h0, pulses});
    chk(model.mem[model.pc], word);
    chk(rd_data_ff, word);
  endtask
  task automatic t_step(input logic cmp, input logic [11:0] d, input logic [11:0] rd,
                        input logic fl, input logic [11:0] nxt, input logic [1:0] sup);
    do_cmd(3'h3, d, 1'b0, cmp, sup);
    chk(rd_data_ff, rd);
    chk({11'h0, fail_ff}, {11'h0, fl});
    chk(addr_ff, nxt);
    chk(model.pc, nxt);
    chk({10'h0, supply_sel_ff}, {10'h0, sup});
  endtask
  task automatic t_refuse();
    do_cmd(3'h2, 12'h000, 1'b0, 1'b0, epv_pkg::SUPPLY_NOMINAL);
    chk({11'h0, fail_ff}, 12'h001);
    chk({11'h0, master_clear_hv_ff}, 12'h000);
    do_cmd(3'h5, 12'h000, 1'b0, 1'b0, epv_pkg::SUPPLY_NOMINAL);
    chk({11'h0, fail_ff}, 12'h001);
    chk({11'h0, prog_verify_strobe_ff}, 12'h001);
  endtask
  task automatic t_exit();
    do_cmd(3'h7, 12'h000, 1'b0, 1'b0, epv_pkg::SUPPLY_NOMINAL);
    chk({11'h0, fail_ff}, 12'h001);
    chk({11'h0, data_oe_ff}, 12'h000);
    do_cmd(3'h1, 12'h000, 1'b0, 1'b0, epv_pkg::SUPPLY_NOMINAL);
    chk({11'h0, in_mode_ff}, 12'h000);
    chk({11'h0, model.in_mode}, 12'h000);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_data = 12'h000;
    cmd_config = 1'b0;
    cmd_cmp_en = 1'b0;
    cmd_supply = 2'h0;
    over_mult = 4'hB;
    need_pulses = 4'h1;
    last_wire = 12'h000;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_refuse();
    t_enter(epv_pkg::SUPPLY_NOMINAL);
    t_program(12'h000, 1'b1, 4'h1, 4'h2, 12'h003, 4'h1, 1'b0, 8'h03);
    t_step(1'b1, 12'h003, 12'h003, 1'b0, 12'h000, epv_pkg::SUPPLY_NOMINAL);
    t_program(12'hA5C, 1'b0, 4'h3, 4'hB, 12'hA5C, 4'h3, 1'b0, 8'h24);
    t_step(1'b0, 12'h000, 12'hA5C, 1'b0, 12'h001, epv_pkg::SUPPLY_NOMINAL);
    t_program(12'h123, 1'b0, 4'h9, 4'hB, 12'hFFF, 4'h8, 1'b1, 8'h08);
    t_exit();
    t_enter(epv_pkg::SUPPLY_MIN);
    t_step(1'b1, 12'h003, 12'h003, 1'b0, 12'h000, epv_pkg::SUPPLY_MIN);
    t_step(1'b1, 12'hA5C, 12'hA5C, 1'b0, 12'h001, epv_pkg::SUPPLY_MIN);
    t_step(1'b1, 12'h000, 12'hFFF, 1'b1, 12'h002, epv_pkg::SUPPLY_MIN);
    t_exit();
    t_enter(epv_pkg::SUPPLY_MAX);
    t_step(1'b1, 12'h003, 12'h003, 1'b0, 12'h000, epv_pkg::SUPPLY_MAX);
    report_and_stop();
  end
  // The planned run takes about 20000 cycles; this allows five times that.
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
endmodule  // eprom_program_verify_port_tb_top
